// ===== core/spsp_pkg.sv
// Package for the per-port status register page
package spsp_pkg;
  // ----------------------------------------
  // Page register offsets
  // ----------------------------------------
  localparam logic [3:0] SPSP_OFS_LINE  = 4'h8;   // port_line_conn_status
  localparam logic [3:0] SPSP_OFS_SPEED = 4'h9;   // port_speed_fault_control
  localparam logic [3:0] SPSP_OFS_CAP   = 4'hA;   // port_connect_capability
  localparam logic [3:0] SPSP_OFS_REL   = 4'hB;   // port_link_reliability
  localparam logic [3:0] SPSP_OFS_ERR   = 4'hC;   // port_codeword_error_count
  localparam logic [3:0] SPSP_OFS_SLEEP = 4'hD;   // port_sleep_standby_control
  localparam logic [3:0] SPSP_OFS_RSV_E = 4'hE;
  localparam logic [3:0] SPSP_OFS_RSV_F = 4'hF;
  // Base register holding page and port selection
  localparam logic [3:0] SPSP_OFS_SEL   = 4'h7;
  localparam int         SPSP_SEL_PORT_LSB = 0;
  localparam int         SPSP_SEL_PAGE_LSB = 5;
  localparam logic [2:0] SPSP_PAGE_PORT = 3'h0;

  // ----------------------------------------
  // Field positions (bit 7 is the leftmost printed bit 0)
  // ----------------------------------------
  localparam int SPSP_B_ASTAT = 6;   // bits 7:6
  localparam int SPSP_B_BSTAT = 4;   // bits 5:4
  localparam int SPSP_B_CHILD = 3;
  localparam int SPSP_B_CON   = 2;
  localparam int SPSP_B_RECEIVE_VALID_FLAG  = 1;
  localparam int SPSP_B_DIS   = 0;
  localparam int SPSP_B_NSPD  = 5;   // bits 7:5
  localparam int SPSP_B_PIE   = 4;
  localparam int SPSP_B_FAULT = 3;
  localparam int SPSP_B_SBF   = 2;
  localparam int SPSP_B_SCRM  = 1;
  localparam int SPSP_B_BONLY = 0;
  localparam int SPSP_B_DC    = 7;
  localparam int SPSP_B_LPP   = 5;
  localparam int SPSP_B_CSPD  = 0;   // bits 2:0
  localparam int SPSP_B_UNREL = 7;
  localparam int SPSP_B_BETA  = 5;

  // ----------------------------------------
  // Encodings, resets and timing
  // ----------------------------------------
  localparam logic [1:0] SPSP_LINE_Z   = 2'h3;
  localparam logic [1:0] SPSP_LINE_ONE = 2'h1;
  localparam logic [1:0] SPSP_LINE_ZRO = 2'h2;
  localparam logic [1:0] SPSP_LINE_BAD = 2'h0;
  localparam logic [2:0] SPSP_S100  = 3'h0;
  localparam logic [2:0] SPSP_S200  = 3'h1;
  localparam logic [2:0] SPSP_S400  = 3'h2;
  localparam logic [2:0] SPSP_S800  = 3'h3;
  localparam logic [2:0] SPSP_S1600 = 3'h4;
  localparam logic [2:0] SPSP_S3200 = 3'h5;
  localparam logic [7:0] SPSP_ERR_MAX = 8'hFF;
  localparam logic [7:0] SPSP_ZERO8   = 8'h00;
  localparam int         SPSP_CLK_MHZ     = 100;
  localparam int         SPSP_DEBOUNCE_MS = 341;
  localparam int         SPSP_DEBOUNCE_CYC = SPSP_DEBOUNCE_MS * SPSP_CLK_MHZ * 1000;

  // ----------------------------------------
  // Per-port line status from the analog front end
  // ----------------------------------------
  typedef struct packed {
    logic [1:0] a_state;       // A-pair arbitration state
    logic [1:0] b_state;       // B-pair arbitration state
    logic       is_child;      // Tree role, 1 for child
    logic       active;        // Port connected, enabled, not suspended
    logic       raw_connect;   // Undebounced connect detect
    logic       beta_mode;     // Port is operating in beta mode
    logic       tones_only;    // Only connection tones seen
    logic       bias_ok;       // Debounced incoming bias (legacy)
    logic       signal_ok;     // Continuous valid signal (beta)
    logic       nego_done;     // Beta speed negotiation completed
    logic       nego_fail;     // Beta negotiation or sync failed
    logic [2:0] beta_speed;    // Speed agreed at beta connection
    logic [2:0] selfid_speed;  // Speed from self-identification
    logic       resuming;      // Port is resuming
    logic       suspending;    // Port is suspending
    logic       standby_err;   // Error seen during standby
    logic       standby_exit;  // Pulse on leaving standby
    logic       remote_sbf_clr;// Remote command clearing standby fault
    logic       bad_codeword;  // Pulse per invalid code word
    logic       port_event;    // Pulse per port event
    logic       remote_err_rd; // Remote access read of error counter
    logic       dc_detect;     // Legacy-style dc connect detect
    logic       beta_only;     // Strapped beta-only
    logic [2:0] cable_speed;   // Port beta speed capability
  } spsp_line_t;

  // Per-port control to the port logic
  typedef struct packed {
    logic disable_port;   // Port kept from becoming active
    logic scramble_off;   // Transmit without scrambling
    logic sbf_discard;    // Pulse: discard standby errors
  } spsp_ctrl_t;

  // Register bus request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } spsp_bus_t;
endpackage

// ===== core/spsp_page.sv
// Per-port status and control register page
module spsp_page
  import spsp_pkg::*;
#(
  parameter int NUM_PORTS    = 3,
  parameter int DEBOUNCE_CYC = spsp_pkg::SPSP_DEBOUNCE_CYC
)(
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  // Register port
  input  wire spsp_pkg::spsp_bus_t   bus,
  output logic [7:0]                 rdata,
  // Port line status and control
  input  wire spsp_pkg::spsp_line_t  line [NUM_PORTS],
  output spsp_pkg::spsp_ctrl_t       ctrl [NUM_PORTS],
  // Link notification
  output logic                       port_event_irq
);
  import spsp_pkg::*;

  localparam int CW = $clog2(DEBOUNCE_CYC + 1);

  initial
  begin
    if (NUM_PORTS < 1 || NUM_PORTS > 15 || DEBOUNCE_CYC < 1)
      $error("spsp_page: unsupported parameters");
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [2:0] page;
    logic [3:0] port;
    logic [7:0] rdata;
    logic       irq;
  } spsp_glob_t;

  typedef struct packed {
    logic          con;
    logic [CW-1:0] deb;
    logic          dis;
    logic          port_event_irq_enable;
    logic          port_event_irq_flag;
    logic          fault;
    logic          sbf;
    logic          scrm;
    logic          unrel;
    logic [2:0]    nspd;
    logic [7:0]    err;
    logic          sbf_clr;
    logic          was_beta_con;
  } spsp_port_t;

  typedef struct packed {
    spsp_glob_t                 g;
    spsp_port_t [NUM_PORTS-1:0] p;
  } spsp_state_t;

  spsp_state_t st;
  spsp_state_t next_st;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    logic       sel_ok;
    logic       on_page;
    logic [7:0] rv;
    logic       stable;
    logic       irq_any;
    next_st = st;
    sel_ok  = (st.g.port < 4'(NUM_PORTS));
    on_page = (st.g.page == SPSP_PAGE_PORT);
    rv      = SPSP_ZERO8;
    irq_any = 1'b0;
    stable  = 1'b0;

    // Base selection register
    if (bus.wr && bus.addr == SPSP_OFS_SEL)
    begin
      next_st.g.port = bus.wdata[SPSP_SEL_PORT_LSB +: 4];
      next_st.g.page = bus.wdata[SPSP_SEL_PAGE_LSB +: 3];
    end
    if (bus.addr == SPSP_OFS_SEL)
      rv = {st.g.page, 1'b0, st.g.port};

    for (int i = 0; i < NUM_PORTS; i++)
    begin
      // Connection debounce
      stable = line[i].raw_connect && (!line[i].beta_mode || line[i].nego_done);
      if (!stable)
      begin
        next_st.p[i].deb = '0;
        next_st.p[i].con = 1'b0;
      end
      else if (st.p[i].deb >= CW'(DEBOUNCE_CYC - 1))
        next_st.p[i].con = 1'b1;
      else
        next_st.p[i].deb = st.p[i].deb + CW'(1);

      // Agreed speed
      if (line[i].beta_mode && line[i].nego_done && !st.p[i].was_beta_con)
        next_st.p[i].nspd = line[i].beta_speed;
      else if (!line[i].beta_mode)
        next_st.p[i].nspd = line[i].selfid_speed;
      next_st.p[i].was_beta_con = line[i].beta_mode && line[i].nego_done;

      // Write-1-to-clear before sets, so sets win
      next_st.p[i].sbf_clr = 1'b0;
      if (bus.wr && on_page && st.g.port == 4'(i))
      begin
        case (bus.addr)
          SPSP_OFS_LINE:  next_st.p[i].dis = bus.wdata[SPSP_B_DIS];
          SPSP_OFS_SPEED:
          begin
            next_st.p[i].port_event_irq_enable  = bus.wdata[SPSP_B_PIE];
            next_st.p[i].scrm = bus.wdata[SPSP_B_SCRM];
            if (bus.wdata[SPSP_B_FAULT])
              next_st.p[i].fault = 1'b0;
            if (bus.wdata[SPSP_B_SBF])
            begin
              next_st.p[i].sbf     = 1'b0;
              next_st.p[i].sbf_clr = st.p[i].sbf;
            end
          end
          SPSP_OFS_REL:
            if (bus.wdata[SPSP_B_UNREL])
              next_st.p[i].unrel = 1'b0;
          default: ;
        endcase
      end
      if (line[i].standby_exit || line[i].remote_sbf_clr)
      begin
        next_st.p[i].sbf     = 1'b0;
        next_st.p[i].sbf_clr = line[i].remote_sbf_clr && st.p[i].sbf;
      end

      // Hardware-set flags
      if ((line[i].resuming && !line[i].bias_ok) || (line[i].suspending && line[i].bias_ok))
        next_st.p[i].fault = 1'b1;
      if (line[i].standby_err)
        next_st.p[i].sbf = 1'b1;
      if (line[i].nego_fail)
        next_st.p[i].unrel = 1'b1;
      if (line[i].port_event && st.p[i].port_event_irq_enable)
        next_st.p[i].port_event_irq_flag = 1'b1;
      irq_any = irq_any || (line[i].port_event && st.p[i].port_event_irq_enable);

      // Error counter: read clears, increment then applies
      if ((bus.rd && on_page && st.g.port == 4'(i) && bus.addr == SPSP_OFS_ERR) ||
          line[i].remote_err_rd)
        next_st.p[i].err = SPSP_ZERO8;
      if (line[i].bad_codeword && st.p[i].err != SPSP_ERR_MAX)
        next_st.p[i].err = ((bus.rd && bus.addr == SPSP_OFS_ERR && on_page && st.g.port == 4'(i))
                            || line[i].remote_err_rd) ? 8'h01 : st.p[i].err + 8'h01;
    end

    // Read mux for the selected port
    if (on_page && sel_ok && bus.addr >= SPSP_OFS_LINE)
    begin
      for (int i = 0; i < NUM_PORTS; i++)
      begin
        if (st.g.port == 4'(i))
        begin
          case (bus.addr)
            SPSP_OFS_LINE:
            begin
              rv[SPSP_B_ASTAT +: 2] = line[i].a_state;
              rv[SPSP_B_BSTAT +: 2] = line[i].b_state;
              rv[SPSP_B_CHILD] = line[i].is_child || !line[i].active;
              rv[SPSP_B_CON]   = st.p[i].con;
              rv[SPSP_B_RECEIVE_VALID_FLAG]  = !line[i].tones_only &&
                                 (line[i].beta_mode ? line[i].signal_ok : line[i].bias_ok);
              rv[SPSP_B_DIS]   = st.p[i].dis;
            end
            SPSP_OFS_SPEED:
            begin
              rv[SPSP_B_NSPD +: 3] = st.p[i].nspd;
              rv[SPSP_B_PIE]   = st.p[i].port_event_irq_enable;
              rv[SPSP_B_FAULT] = st.p[i].fault;
              rv[SPSP_B_SBF]   = st.p[i].sbf;
              rv[SPSP_B_SCRM]  = st.p[i].scrm;
              rv[SPSP_B_BONLY] = line[i].beta_only;
            end
            SPSP_OFS_CAP:
            begin
              rv[SPSP_B_DC]        = line[i].dc_detect;
              rv[SPSP_B_LPP]       = 1'b1;
              rv[SPSP_B_CSPD +: 3] = line[i].cable_speed;
            end
            SPSP_OFS_REL:
            begin
              rv[SPSP_B_UNREL] = st.p[i].unrel;
              rv[SPSP_B_BETA]  = line[i].beta_mode;
            end
            SPSP_OFS_ERR: rv = st.p[i].err;
            default:      rv = SPSP_ZERO8;
          endcase
        end
      end
    end
    next_st.g.rdata = bus.rd ? rv : SPSP_ZERO8;
    next_st.g.irq   = irq_any;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      st <= '0;
    else
      st <= next_st;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign rdata          = st.g.rdata;
  assign port_event_irq = st.g.irq;
  always_comb
  begin
    for (int i = 0; i < NUM_PORTS; i++)
    begin
      ctrl[i].disable_port = st.p[i].dis;
      ctrl[i].scramble_off = st.p[i].scrm;
      ctrl[i].sbf_discard  = st.p[i].sbf_clr;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_unimpl_zero;
    @(posedge mclk) disable iff (!rst_n)
    (bus.rd && bus.addr >= SPSP_OFS_LINE && st.g.port >= 4'(NUM_PORTS)) |=> rdata == SPSP_ZERO8;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented port read nonzero");

  property p_rsvd_zero;
    @(posedge mclk) disable iff (!rst_n)
    (bus.rd && bus.addr >= SPSP_OFS_RSV_E) |=> rdata == SPSP_ZERO8;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved register read nonzero");

  property p_err_sat;
    @(posedge mclk) disable iff (!rst_n)
    st.p[0].err == SPSP_ERR_MAX && !line[0].remote_err_rd && !bus.rd |=> st.p[0].err == SPSP_ERR_MAX;
  endproperty
  a_err_sat: assert property (p_err_sat) else $error("error counter wrapped");

  property p_err_clr;
    @(posedge mclk) disable iff (!rst_n)
    (bus.rd && bus.addr == SPSP_OFS_ERR && st.g.page == SPSP_PAGE_PORT && st.g.port == 4'h0
     && !line[0].bad_codeword) |=> st.p[0].err == SPSP_ZERO8;
  endproperty
  a_err_clr: assert property (p_err_clr) else $error("error counter not cleared by read");

  property p_con_needs_stable;
    @(posedge mclk) disable iff (!rst_n)
    $rose(st.p[0].con) |-> $past(line[0].raw_connect, 1) && st.p[0].deb >= CW'(DEBOUNCE_CYC - 1);
  endproperty
  a_con_needs_stable: assert property (p_con_needs_stable) else $error("connect set early");

  property p_fault_set;
    @(posedge mclk) disable iff (!rst_n)
    (line[0].resuming && !line[0].bias_ok) |=> st.p[0].fault;
  endproperty
  a_fault_set: assert property (p_fault_set) else $error("resume fault not flagged");

  property p_pei_set;
    @(posedge mclk) disable iff (!rst_n)
    (line[0].port_event && st.p[0].port_event_irq_enable) |=> st.p[0].port_event_irq_flag ##0 port_event_irq;
  endproperty
  a_pei_set: assert property (p_pei_set) else $error("port event not raised");

  property p_dis_ctrl;
    @(posedge mclk) disable iff (!rst_n)
    (bus.wr && bus.addr == SPSP_OFS_LINE && st.g.page == SPSP_PAGE_PORT && st.g.port == 4'h0)
    |=> ctrl[0].disable_port == $past(bus.wdata[SPSP_B_DIS], 1);
  endproperty
  a_dis_ctrl: assert property (p_dis_ctrl) else $error("disable not applied");

  property p_scrm_ctrl;
    @(posedge mclk) disable iff (!rst_n)
    (bus.wr && bus.addr == SPSP_OFS_SPEED && st.g.page == SPSP_PAGE_PORT && st.g.port == 4'h0)
    |=> ctrl[0].scramble_off == $past(bus.wdata[SPSP_B_SCRM], 1);
  endproperty
  a_scrm_ctrl: assert property (p_scrm_ctrl) else $error("scrambler bit not applied");

  property p_rdata_idle;
    @(posedge mclk) disable iff (!rst_n)
    !bus.rd |=> rdata == SPSP_ZERO8;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");

  property p_astat_rd;
    @(posedge mclk) disable iff (!rst_n)
    (bus.rd && bus.addr == SPSP_OFS_LINE && st.g.page == SPSP_PAGE_PORT && st.g.port == 4'h0)
    |=> rdata[SPSP_B_ASTAT +: 2] == $past(line[0].a_state, 1);
  endproperty
  a_astat_rd: assert property (p_astat_rd) else $error("A-pair state misread");

  property p_bstat_rd;
    @(posedge mclk) disable iff (!rst_n)
    (bus.rd && bus.addr == SPSP_OFS_LINE && st.g.page == SPSP_PAGE_PORT && st.g.port == 4'h0)
    |=> rdata[SPSP_B_BSTAT +: 2] == $past(line[0].b_state, 1);
  endproperty
  a_bstat_rd: assert property (p_bstat_rd) else $error("B-pair state misread");

  property p_child_idle;
    @(posedge mclk) disable iff (!rst_n)
    (bus.rd && bus.addr == SPSP_OFS_LINE && st.g.page == SPSP_PAGE_PORT && st.g.port == 4'h0
     && !line[0].active) |=> rdata[SPSP_B_CHILD];
  endproperty
  a_child_idle: assert property (p_child_idle) else $error("inactive port not child");

  property p_receive_valid_flag_tones;
    @(posedge mclk) disable iff (!rst_n)
    (bus.rd && bus.addr == SPSP_OFS_LINE && st.g.page == SPSP_PAGE_PORT && st.g.port == 4'h0
     && line[0].tones_only) |=> !rdata[SPSP_B_RECEIVE_VALID_FLAG];
  endproperty
  a_receive_valid_flag_tones: assert property (p_receive_valid_flag_tones) else $error("receive valid on tones");

  property p_con_drop;
    @(posedge mclk) disable iff (!rst_n)
    !line[0].raw_connect |=> !st.p[0].con;
  endproperty
  a_con_drop: assert property (p_con_drop) else $error("connect kept without line");

  property p_nspd_legacy;
    @(posedge mclk) disable iff (!rst_n)
    !line[0].beta_mode |=> st.p[0].nspd == $past(line[0].selfid_speed, 1);
  endproperty
  a_nspd_legacy: assert property (p_nspd_legacy) else $error("legacy speed not loaded");

  property p_susp_fault;
    @(posedge mclk) disable iff (!rst_n)
    (line[0].suspending && line[0].bias_ok) |=> st.p[0].fault;
  endproperty
  a_susp_fault: assert property (p_susp_fault) else $error("suspend fault not flagged");

  property p_fault_w1c;
    @(posedge mclk) disable iff (!rst_n)
    (bus.wr && bus.addr == SPSP_OFS_SPEED && st.g.page == SPSP_PAGE_PORT && st.g.port == 4'h0
     && bus.wdata[SPSP_B_FAULT] && !(line[0].resuming && !line[0].bias_ok)
     && !(line[0].suspending && line[0].bias_ok)) |=> !st.p[0].fault;
  endproperty
  a_fault_w1c: assert property (p_fault_w1c) else $error("fault not cleared by write");

  property p_sbf_set;
    @(posedge mclk) disable iff (!rst_n)
    line[0].standby_err |=> st.p[0].sbf;
  endproperty
  a_sbf_set: assert property (p_sbf_set) else $error("standby fault not flagged");

  property p_sbf_exit;
    @(posedge mclk) disable iff (!rst_n)
    (line[0].standby_exit && !line[0].standby_err) |=> !st.p[0].sbf;
  endproperty
  a_sbf_exit: assert property (p_sbf_exit) else $error("standby fault kept on exit");

  property p_pei_cause;
    @(posedge mclk) disable iff (!rst_n)
    $rose(st.p[0].port_event_irq_flag) |-> $past(line[0].port_event && st.p[0].port_event_irq_enable, 1);
  endproperty
  a_pei_cause: assert property (p_pei_cause) else $error("port event flag without cause");
endmodule

// ===== tb/spsp_link_model.sv
// Link-layer controller model that drives the page's register port
module spsp_link_model
  import spsp_pkg::*;
(
  // Clock and register port
  input  wire logic           mclk,
  output spsp_pkg::spsp_bus_t bus,
  input  wire logic [7:0]     rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial bus = '0;
  // Entered at a rising edge; the last edge is left free for the next request
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus.wr <= 1'b0;
    @(posedge mclk);
  endtask
  // Read data is handed back raw, the child flag is never acted on
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus.rd <= 1'b0;
    #1 v = rdata;
    @(posedge mclk);
  endtask
  // Page 0 and the port number go to the selection register first
  task automatic sel(input logic [3:0] p);
    wr(SPSP_OFS_SEL, {SPSP_PAGE_PORT, 1'b0, p});
  endtask
endmodule

// ===== tb/serial_bus_phy_port_status_page_bench.sv
// Self-checking bench for the per-port status register page
module serial_bus_phy_port_status_page_bench;
  import spsp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DB = 20;
  // Row: {A/B states, 2'b0 child active beta tones bias signal, expected 0x8}
  localparam logic [19:0] ROWS [6] = '{20'hF_12F2, 20'h6_0068, 20'h9_399A, 20'h0_1D00, 20'hC_11C0, 20'h5_3A58};
  localparam logic [63:0] RV = 64'h0800_2000_0000_0000;
  localparam logic [15:0] FLT = 16'h9A74;
  logic       mclk;
  logic       rst_n;
  logic       irq;
  logic       seen_discard;
  logic [7:0] rdata;
  logic [7:0] d;
  logic [3:0] v;
  int         n_mismatch;
  int         num_checks;
  int         cyc;
  spsp_bus_t  bus;
  spsp_line_t line [3];
  spsp_ctrl_t ctrl [3];

  spsp_page #(.NUM_PORTS(3), .DEBOUNCE_CYC(DB)) spsp_page_inst (.mclk(mclk), .rst_n(rst_n), .bus(bus),
    .rdata(rdata), .line(line), .ctrl(ctrl), .port_event_irq(irq));
  spsp_link_model spsp_link_model_inst (.mclk(mclk), .bus(bus), .rdata(rdata));

  // ----------------------------------------
  // Clock, timeout and helpers
  // ----------------------------------------
  initial mclk = 1'b0;
  always #5 mclk = ~mclk;
  always @(posedge mclk)
  begin
    cyc++;
    if (ctrl[0].sbf_discard === 1'b1)
      seen_discard <= 1'b1;
    if (cyc == 12000)
    begin
      n_mismatch++;
      stop_test();
    end
  end
  task automatic stop_test();
    if (n_mismatch == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] x);
    spsp_link_model_inst.wr(a, x);
  endtask
  task automatic sel(input logic [3:0] p);
    spsp_link_model_inst.sel(p);
  endtask
  // Read a register and compare the masked bits
  task automatic rc(input logic [3:0] a, input logic [7:0] m, input logic [7:0] exp);
    spsp_link_model_inst.rd(a, d);
    check8(d & m, exp);
  endtask
  task automatic put(input int j, input logic [3:0] ab, input logic [7:0] fl);
    line[j].a_state <= ab[3:2];
    line[j].b_state <= ab[1:0];
    {line[j].is_child, line[j].active, line[j].beta_mode} <= fl[5:3];
    {line[j].tones_only, line[j].bias_ok, line[j].signal_ok} <= fl[2:0];
  endtask
  task automatic hw_reset();
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    rst_n = 1'b0;
    n_mismatch = 0;
    num_checks = 0;
    cyc = 0;
    seen_discard = 1'b0;
    for (int j = 0; j < 3; j++)
      line[j] = '0;
    hw_reset();
    for (int k = 0; k < 8; k++)
      rc(4'(k + 8), 8'hFF, RV[63 - 8 * k -: 8]);
    // Line state rows, other ports hold the inverse
    for (int i = 0; i < 6; i++)
    begin
      for (int j = 0; j < 3; j++)
        put(j, (j == i % 3) ? ROWS[i][19:16] : ~ROWS[i][19:16], (j == i % 3) ? ROWS[i][15:8] : ~ROWS[i][15:8]);
      sel(4'(i % 3));
      rc(SPSP_OFS_LINE, 8'hFA, ROWS[i][7:0]);
    end
    for (int j = 0; j < 3; j++)
      put(j, 4'hF, 8'hFF);
    sel(4'h3);
    for (int k = 8; k < 16; k++)
      rc(4'(k), 8'hFF, 8'h00);
    for (int j = 0; j < 3; j++)
      line[j] <= '0;
    // Disable and scrambler bits, read-only bits ignore writes
    sel(4'h1);
    wr(SPSP_OFS_LINE, 8'hFF);
    wr(SPSP_OFS_SPEED, 8'hE3);
    wr(SPSP_OFS_RSV_E, 8'hFF);
    check8({6'h00, ctrl[1].disable_port, ctrl[1].scramble_off}, 8'h03);
    check8({4'h0, ctrl[0].disable_port, ctrl[0].scramble_off, ctrl[2].disable_port, ctrl[2].scramble_off}, 8'h00);
    rc(SPSP_OFS_LINE, 8'hFF, 8'h09);
    rc(SPSP_OFS_SPEED, 8'hFF, 8'h02);
    rc(SPSP_OFS_RSV_E, 8'hFF, 8'h00);
    line[1].dc_detect <= 1'b1;
    line[1].beta_only <= 1'b1;
    line[1].cable_speed <= SPSP_S1600;
    @(posedge mclk);
    rc(SPSP_OFS_CAP, 8'hFF, 8'hA4);
    rc(SPSP_OFS_SPEED, 8'hFF, 8'h03);
    line[1].nego_fail <= 1'b1;
    line[1].beta_mode <= 1'b1;
    @(posedge mclk);
    line[1].nego_fail <= 1'b0;
    rc(SPSP_OFS_REL, 8'hFF, 8'hA0);
    wr(SPSP_OFS_REL, 8'h80);
    rc(SPSP_OFS_REL, 8'hFF, 8'h20);
    line[1] <= '0;
    // Port event enable on port 2 only
    sel(4'h2);
    wr(SPSP_OFS_SPEED, 8'h10);
    for (int j = 2; j >= 0; j -= 2)
    begin
      line[j].port_event <= 1'b1;
      @(posedge mclk);
      line[j].port_event <= 1'b0;
      #1 check8({7'h00, irq}, {7'h00, j == 2});
      @(posedge mclk);
      #1 check8({7'h00, irq}, 8'h00);
      @(posedge mclk);
    end
    // Codeword counter: count, clear on read, saturate, remote clear
    repeat (3)
    begin
      line[2].bad_codeword <= 1'b1;
      @(posedge mclk);
      line[2].bad_codeword <= 1'b0;
      @(posedge mclk);
    end
    rc(SPSP_OFS_ERR, 8'hFF, 8'h03);
    rc(SPSP_OFS_ERR, 8'hFF, 8'h00);
    line[2].bad_codeword <= 1'b1;
    repeat (260) @(posedge mclk);
    line[2].bad_codeword <= 1'b0;
    @(posedge mclk);
    rc(SPSP_OFS_ERR, 8'hFF, 8'hFF);
    line[2].bad_codeword <= 1'b1;
    @(posedge mclk);
    line[2].bad_codeword <= 1'b0;
    line[2].remote_err_rd <= 1'b1;
    @(posedge mclk);
    line[2].remote_err_rd <= 1'b0;
    @(posedge mclk);
    rc(SPSP_OFS_ERR, 8'hFF, 8'h00);
    // Suspend and resume faults, cleared by writing 1
    sel(4'h0);
    wr(SPSP_OFS_LINE, 8'h01);
    check8({7'h00, ctrl[0].disable_port}, 8'h01);
    wr(SPSP_OFS_LINE, 8'h00);
    rc(SPSP_OFS_ERR, 8'hFF, 8'h00);
    for (int k = 0; k < 4; k++)
    begin
      v = FLT[15 - 4 * k -: 4];
      {line[0].resuming, line[0].suspending, line[0].bias_ok} <= v[3:1];
      repeat (3) @(posedge mclk);
      rc(SPSP_OFS_SPEED, 8'h08, {4'h0, v[0], 3'h0});
      {line[0].resuming, line[0].suspending, line[0].bias_ok} <= 3'h0;
      @(posedge mclk);
      wr(SPSP_OFS_SPEED, 8'h08);
      rc(SPSP_OFS_SPEED, 8'h08, 8'h00);
    end
    // Standby fault cleared by write, exit and remote command
    for (int k = 0; k < 3; k++)
    begin
      line[0].standby_err <= 1'b1;
      @(posedge mclk);
      line[0].standby_err <= 1'b0;
      @(posedge mclk);
      rc(SPSP_OFS_SPEED, 8'h04, 8'h04);
      if (k == 0)
        wr(SPSP_OFS_SPEED, 8'h04);
      line[0].standby_exit <= (k == 1);
      line[0].remote_sbf_clr <= (k == 2);
      @(posedge mclk);
      line[0] <= '0;
      @(posedge mclk);
      rc(SPSP_OFS_SPEED, 8'h04, 8'h00);
    end
    check8({7'h00, seen_discard}, 8'h01);
    // Debounce, negotiated speed, hardware reset of state
    hw_reset();
    check8({7'h00, ctrl[1].disable_port}, 8'h00);
    sel(4'h1);
    line[1].raw_connect <= 1'b1;
    line[1].selfid_speed <= SPSP_S400;
    repeat (DB / 2) @(posedge mclk);
    rc(SPSP_OFS_LINE, 8'h04, 8'h00);
    repeat (2 * DB) @(posedge mclk);
    rc(SPSP_OFS_LINE, 8'h04, 8'h04);
    rc(SPSP_OFS_SPEED, 8'hE0, 8'h40);
    sel(4'h2);
    {line[2].beta_mode, line[2].raw_connect} <= 2'h3;
    line[2].beta_speed <= SPSP_S3200;
    repeat (2 * DB) @(posedge mclk);
    rc(SPSP_OFS_LINE, 8'h04, 8'h00);
    line[2].nego_done <= 1'b1;
    repeat (2 * DB) @(posedge mclk);
    rc(SPSP_OFS_LINE, 8'h04, 8'h04);
    rc(SPSP_OFS_SPEED, 8'hE0, 8'hA0);
    hw_reset();
    sel(4'h1);
    rc(SPSP_OFS_LINE, 8'h04, 8'h00);
    stop_test();
  end
endmodule
